// ===== core/asq_pkg.sv
package asq_pkg;
   // ***********************
   // bus and data widths
   // ***********************
   localparam int AW = 5;
   localparam int DW = 16;
   localparam int SW = 12;
   localparam int ENTRY_CH_BIT = 12;
   // ***********************
   // register offsets
   // ***********************
   localparam logic [AW-1:0] A_OP_MODE = 5'h00;
   localparam logic [AW-1:0] A_BUF_MODE = 5'h01;
   localparam logic [AW-1:0] A_START = 5'h02;
   localparam logic [AW-1:0] A_ABORT = 5'h03;
   localparam logic [AW-1:0] A_SCAN = 5'h04;
   localparam logic [AW-1:0] A_OSC = 5'h05;
   localparam logic [AW-1:0] A_INTERVAL = 5'h06;
   localparam logic [AW-1:0] A_EVT_EN = 5'h07;
   localparam logic [AW-1:0] A_CMP_EN = 5'h08;
   localparam logic [AW-1:0] A_HI_FLAGS = 5'h09;
   localparam logic [AW-1:0] A_LO_FLAGS = 5'h0A;
   localparam logic [AW-1:0] A_ACCUM_EN = 5'h0B;
   localparam logic [AW-1:0] A_LIM_HI0 = 5'h0C;
   localparam logic [AW-1:0] A_LIM_LO0 = 5'h0D;
   localparam logic [AW-1:0] A_LIM_HI1 = 5'h0E;
   localparam logic [AW-1:0] A_LIM_LO1 = 5'h0F;
   localparam logic [AW-1:0] A_ACC_FIRST = 5'h10;
   localparam logic [AW-1:0] A_ACC_SECOND = 5'h11;
   localparam logic [AW-1:0] A_STATUS = 5'h12;
   localparam logic [AW-1:0] A_DATA = 5'h13;
   // ***********************
   // encodings and reset values
   // ***********************
   localparam logic [2:0] OPM_AUTO = 3'h6;
   localparam logic [2:0] OPM_HP = 3'h7;
   localparam logic [2:0] BUF_STOP = 3'h0;
   localparam logic [2:0] BUF_START = 3'h1;
   localparam logic [2:0] BUF_PRE = 3'h4;
   localparam logic [2:0] BUF_POST = 3'h6;
   localparam logic [1:0] SCAN_BOTH = 2'h3;
   localparam logic [1:0] SCAN_SECOND = 2'h2;
   localparam logic [1:0] SCAN_RST = 2'h1;
   localparam logic [1:0] FLAG_CLR = 2'h3;
   localparam logic [7:0] INTERVAL_RST = 8'h01;
   localparam int MAN_SCL_PER_SAMPLE = 18;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} asq_state_t;
endpackage

// ===== core/asq_core.sv
`timescale 1ns/100ps
module asq_core #(
   parameter int LOW_OSC_DIV = 32,
   parameter int BUF_DEPTH = 16,
   parameter int ACC_CNT = 16
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [asq_pkg::AW-1:0] i_addr,
   input wire logic [asq_pkg::DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [asq_pkg::DW-1:0] o_rdata,
   input wire logic i_scl,
   input wire logic i_host_read,
   output logic o_conv_start,
   output logic o_conv_ch,
   input wire logic i_conv_done,
   input wire logic [asq_pkg::SW-1:0] i_conv_data,
   output logic o_alert,
   output logic o_busy,
   output logic o_man_valid,
   output logic [asq_pkg::DW-1:0] o_man_data
);
   import asq_pkg::*;

   localparam int PW = $clog2(BUF_DEPTH);
   localparam logic [PW:0] FILL_LAST = (PW+1)'(BUF_DEPTH - 1);
   localparam logic [PW:0] FILL_FULL = (PW+1)'(BUF_DEPTH);
   localparam logic [5:0] HP_LAST1 = 6'(ACC_CNT - 1);
   localparam logic [5:0] HP_LAST2 = 6'(2 * ACC_CNT - 1);
   localparam logic [4:0] MAN_LAST = 5'(MAN_SCL_PER_SAMPLE - 1);
   localparam logic [7:0] DIV_LAST = 8'(LOW_OSC_DIV - 1);

   // ***********************
   // functions
   // ***********************
   function automatic logic fn_cross(input logic [SW-1:0] d,
                                     input logic [SW-1:0] hi,
                                     input logic [SW-1:0] lo);
      fn_cross = (d > hi) || (d < lo);
   endfunction

   function automatic logic fn_next(input logic [1:0] scan, input logic ch);
      if (scan == SCAN_BOTH) begin
         fn_next = ~ch;
      end else begin
         fn_next = (scan == SCAN_SECOND);
      end
   endfunction

   function automatic logic [PW-1:0] fn_inc(input logic [PW-1:0] p);
      fn_inc = (p == PW'(BUF_DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   // ***********************
   // state and configuration
   // ***********************
   asq_state_t state_r;
   logic [2:0] operating_mode_select_r;
   logic [2:0] buffer_capture_mode_r;
   logic [1:0] channel_scan_select_r;
   logic oscillator_choice_r;
   logic [7:0] conversion_interval_count_r;
   logic [1:0] channel_event_enables_r;
   logic comparator_block_enable_r;
   logic accumulator_enable_r;
   logic [SW-1:0] lim_hi_r [2];
   logic [SW-1:0] lim_lo_r [2];
   logic [1:0] hi_flag_r;
   logic [1:0] lo_flag_r;
   logic [15:0] acc_r [2];
   logic [5:0] hp_cnt_r;
   logic acc_valid_r;
   logic [DW-1:0] buf_r [BUF_DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] fill_r;
   logic trig_r;
   logic seq_on_r;
   logic scl_s1, scl_s2, scl_s3;
   logic host_s1, host_s2;
   logic [4:0] scl_cnt_r;
   logic [7:0] div_cnt_r;
   logic [7:0] ival_cnt_r;

   logic start_p, abort_p, conv_ok, auto_run, hp_run, hit;
   logic store_en, stop_now, man_en, man_req, tick, ival_hit, data_rd;

   assign start_p = i_wr && (i_addr == A_START) && i_wdata[0];
   assign abort_p = i_wr && (i_addr == A_ABORT) && i_wdata[0];
   assign conv_ok = (state_r == ST_CONV) && i_conv_done;
   assign auto_run = o_busy && (operating_mode_select_r == OPM_AUTO);
   assign hp_run = o_busy && (operating_mode_select_r == OPM_HP);
   assign hit = comparator_block_enable_r && channel_event_enables_r[o_conv_ch]
                && fn_cross(i_conv_data, lim_hi_r[o_conv_ch], lim_lo_r[o_conv_ch]);
   assign data_rd = i_rd && (i_addr == A_DATA);

   // ***********************
   // capture decision
   // ***********************
   always_comb begin
      store_en = 1'b0;
      stop_now = 1'b0;
      if (conv_ok && auto_run) begin
         case (buffer_capture_mode_r)
            BUF_PRE: begin
               if (hit) begin
                  stop_now = 1'b1;
               end else begin
                  store_en = 1'b1;
               end
            end
            BUF_POST: begin
               if (trig_r) begin
                  store_en = 1'b1;
                  stop_now = (fill_r == FILL_LAST);
               end
            end
            BUF_START: begin
               store_en = 1'b1;
               stop_now = (fill_r == FILL_LAST);
            end
            default: begin
               store_en = 1'b1;
            end
         endcase
      end
      if (conv_ok && hp_run) begin
         stop_now = !abort_p && (hp_cnt_r == ((channel_scan_select_r == SCAN_BOTH) ?
                                              HP_LAST2 : HP_LAST1));
      end
   end

   // ***********************
   // pin synchronisers and manual pacing
   // ***********************
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         host_s1 <= 1'b0;
         host_s2 <= 1'b0;
      end else begin
         scl_s1 <= i_scl;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         host_s1 <= i_host_read;
         host_s2 <= host_s1;
      end
   end

   assign man_en = !operating_mode_select_r[1] && host_s2
                   && (!operating_mode_select_r[2] || seq_on_r);
   assign man_req = man_en && scl_s2 && !scl_s3 && (scl_cnt_r == MAN_LAST)
                    && (state_r == ST_IDLE);

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         scl_cnt_r <= '0;
      end else if (!man_en) begin
         scl_cnt_r <= '0;
      end else if (scl_s2 && !scl_s3) begin
         scl_cnt_r <= (scl_cnt_r == MAN_LAST) ? '0 : scl_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         seq_on_r <= 1'b0;
      end else if (abort_p) begin
         seq_on_r <= 1'b0;
      end else if (start_p && !operating_mode_select_r[1]) begin
         seq_on_r <= 1'b1;
      end
   end

   // ***********************
   // oscillator tick and interval
   // ***********************
   assign tick = oscillator_choice_r ? (div_cnt_r == '0) : 1'b1;
   assign ival_hit = tick && (ival_cnt_r >= conversion_interval_count_r);

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= (div_cnt_r == DIV_LAST) ? '0 : div_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         ival_cnt_r <= '0;
      end else if (conv_ok) begin
         ival_cnt_r <= 8'h01;
      end else if (tick && ival_cnt_r != 8'hFF) begin
         ival_cnt_r <= ival_cnt_r + 8'h01;
      end
   end

   // ***********************
   // sequencer
   // ***********************
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         state_r <= ST_IDLE;
         o_busy <= 1'b0;
         o_conv_start <= 1'b0;
      end else begin
         o_conv_start <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start_p && operating_mode_select_r[2:1] == OPM_AUTO[2:1]) begin
                  o_busy <= 1'b1;
                  state_r <= ST_CONV;
                  o_conv_start <= 1'b1;
               end else if (man_req) begin
                  state_r <= ST_CONV;
                  o_conv_start <= 1'b1;
               end
            end
            ST_WAIT: begin
               if (abort_p) begin
                  o_busy <= 1'b0;
                  state_r <= ST_IDLE;
               end else if (ival_hit) begin
                  state_r <= ST_CONV;
                  o_conv_start <= 1'b1;
               end
            end
            ST_CONV: begin
               if (abort_p && o_busy) begin
                  o_busy <= 1'b0;
                  state_r <= ST_IDLE;
               end else if (conv_ok) begin
                  if (!o_busy || stop_now) begin
                     o_busy <= 1'b0;
                     state_r <= ST_IDLE;
                  end else begin
                     state_r <= ST_WAIT;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_conv_ch <= 1'b0;
      end else if (start_p) begin
         o_conv_ch <= (channel_scan_select_r == SCAN_SECOND);
      end else if (conv_ok) begin
         o_conv_ch <= !operating_mode_select_r[2] ? 1'b0
                      : fn_next(channel_scan_select_r, o_conv_ch);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_man_valid <= 1'b0;
         o_man_data <= '0;
      end else begin
         o_man_valid <= conv_ok && !o_busy;
         if (conv_ok && !o_busy) begin
            o_man_data <= {3'h0, o_conv_ch, i_conv_data};
         end
      end
   end

   // ***********************
   // data buffer
   // ***********************
   always_ff @(posedge i_core_clk) begin
      if (store_en) begin
         buf_r[wr_ptr_r] <= {3'h0, o_conv_ch, i_conv_data};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         fill_r <= '0;
      end else if (start_p && operating_mode_select_r == OPM_AUTO) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         fill_r <= '0;
      end else if (store_en) begin
         wr_ptr_r <= fn_inc(wr_ptr_r);
         if (fill_r == FILL_FULL) begin
            rd_ptr_r <= fn_inc(wr_ptr_r);
         end else begin
            fill_r <= fill_r + 1'b1;
         end
      end else if (data_rd && operating_mode_select_r != OPM_HP) begin
         rd_ptr_r <= fn_inc(rd_ptr_r);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         trig_r <= 1'b0;
      end else if (start_p) begin
         trig_r <= 1'b0;
      end else if (conv_ok && auto_run && hit && buffer_capture_mode_r == BUF_POST) begin
         trig_r <= 1'b1;
      end
   end

   // ***********************
   // comparator flags and alert
   // ***********************
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         hi_flag_r <= '0;
         lo_flag_r <= '0;
      end else begin
         hi_flag_r <= (hi_flag_r & ~((i_wr && i_addr == A_HI_FLAGS) ? i_wdata[1:0] : 2'h0))
                      | {2{conv_ok && auto_run && hit
                           && i_conv_data > lim_hi_r[o_conv_ch]}}
                        & (2'h1 << o_conv_ch);
         lo_flag_r <= (lo_flag_r & ~((i_wr && i_addr == A_LO_FLAGS) ? i_wdata[1:0] : 2'h0))
                      | {2{conv_ok && auto_run && hit
                           && i_conv_data < lim_lo_r[o_conv_ch]}}
                        & (2'h1 << o_conv_ch);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_alert <= 1'b0;
      end else begin
         o_alert <= comparator_block_enable_r
                    && |((hi_flag_r | lo_flag_r) & channel_event_enables_r);
      end
   end

   // ***********************
   // accumulators
   // ***********************
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         acc_r[0] <= '0;
         acc_r[1] <= '0;
         hp_cnt_r <= '0;
         acc_valid_r <= 1'b0;
      end else if (start_p && operating_mode_select_r == OPM_HP) begin
         acc_r[0] <= '0;
         acc_r[1] <= '0;
         hp_cnt_r <= '0;
         acc_valid_r <= 1'b0;
      end else if (conv_ok && hp_run) begin
         if (accumulator_enable_r) begin
            acc_r[o_conv_ch] <= acc_r[o_conv_ch] + 16'(i_conv_data);
         end
         hp_cnt_r <= hp_cnt_r + 6'h01;
         acc_valid_r <= stop_now;
      end
   end

   // ***********************
   // register bus
   // ***********************
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         operating_mode_select_r <= '0;
         buffer_capture_mode_r <= '0;
         channel_scan_select_r <= SCAN_RST;
         oscillator_choice_r <= 1'b0;
         conversion_interval_count_r <= INTERVAL_RST;
         channel_event_enables_r <= '0;
         comparator_block_enable_r <= 1'b0;
         accumulator_enable_r <= 1'b0;
         lim_hi_r[0] <= '1;
         lim_hi_r[1] <= '1;
         lim_lo_r[0] <= '0;
         lim_lo_r[1] <= '0;
      end else if (i_wr) begin
         case (i_addr)
            A_OP_MODE: operating_mode_select_r <= i_wdata[2:0];
            A_BUF_MODE: buffer_capture_mode_r <= i_wdata[2:0];
            A_SCAN: channel_scan_select_r <= i_wdata[1:0];
            A_OSC: oscillator_choice_r <= i_wdata[0];
            A_INTERVAL: conversion_interval_count_r <= i_wdata[7:0];
            A_EVT_EN: channel_event_enables_r <= i_wdata[1:0];
            A_CMP_EN: comparator_block_enable_r <= i_wdata[0];
            A_ACCUM_EN: accumulator_enable_r <= i_wdata[0];
            A_LIM_HI0: lim_hi_r[0] <= i_wdata[SW-1:0];
            A_LIM_LO0: lim_lo_r[0] <= i_wdata[SW-1:0];
            A_LIM_HI1: lim_hi_r[1] <= i_wdata[SW-1:0];
            A_LIM_LO1: lim_lo_r[1] <= i_wdata[SW-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst || !i_rd) begin
         o_rdata <= '0;
      end else begin
         case (i_addr)
            A_OP_MODE: o_rdata <= DW'(operating_mode_select_r);
            A_BUF_MODE: o_rdata <= DW'(buffer_capture_mode_r);
            A_SCAN: o_rdata <= DW'(channel_scan_select_r);
            A_OSC: o_rdata <= DW'(oscillator_choice_r);
            A_INTERVAL: o_rdata <= DW'(conversion_interval_count_r);
            A_EVT_EN: o_rdata <= DW'(channel_event_enables_r);
            A_CMP_EN: o_rdata <= DW'(comparator_block_enable_r);
            A_HI_FLAGS: o_rdata <= DW'(hi_flag_r);
            A_LO_FLAGS: o_rdata <= DW'(lo_flag_r);
            A_ACCUM_EN: o_rdata <= DW'(accumulator_enable_r);
            A_LIM_HI0: o_rdata <= DW'(lim_hi_r[0]);
            A_LIM_LO0: o_rdata <= DW'(lim_lo_r[0]);
            A_LIM_HI1: o_rdata <= DW'(lim_hi_r[1]);
            A_LIM_LO1: o_rdata <= DW'(lim_lo_r[1]);
            A_ACC_FIRST: o_rdata <= acc_r[0];
            A_ACC_SECOND: o_rdata <= acc_r[1];
            A_STATUS: o_rdata <= DW'({acc_valid_r, trig_r, o_busy, fill_r});
            A_DATA: o_rdata <= (operating_mode_select_r == OPM_HP) ? '0
                               : buf_r[rd_ptr_r];
            default: o_rdata <= '0;
         endcase
      end
   end

   // ***********************
   // assertions
   // ***********************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_hp_last;
      conv_ok && hp_run && stop_now;
   endsequence
   sequence s_idle_done;
      !o_busy && acc_valid_r && state_r == ST_IDLE;
   endsequence

   property p_alternate;
      (conv_ok && channel_scan_select_r == SCAN_BOTH && operating_mode_select_r[2]
       && !start_p) |=> o_conv_ch != $past(o_conv_ch);
   endproperty
   a_alternate: assert property (p_alternate) else $error("channel did not alternate");

   property p_enter;
      (start_p && state_r == ST_IDLE && operating_mode_select_r == OPM_AUTO)
         |=> o_busy && o_conv_start;
   endproperty
   a_enter: assert property (p_enter) else $error("autonomous start missed");

   property p_paced;
      (state_r == ST_WAIT && !abort_p && ival_hit) |=> o_conv_start && state_r == ST_CONV;
   endproperty
   a_paced: assert property (p_paced) else $error("self paced start missed");

   property p_alert;
      (comparator_block_enable_r && ((hi_flag_r | lo_flag_r) & channel_event_enables_r) != 0)
         |=> o_alert;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not driven");

   property p_pre_halt;
      (conv_ok && auto_run && buffer_capture_mode_r == BUF_PRE && hit)
         |-> !store_en ##1 !o_busy;
   endproperty
   a_pre_halt: assert property (p_pre_halt) else $error("pre-event did not halt");

   property p_abort;
      (abort_p && o_busy && state_r != ST_IDLE) |=> !o_busy && !store_en;
   endproperty
   a_abort: assert property (p_abort) else $error("abort ignored");

   property p_post_wait;
      (store_en && buffer_capture_mode_r == BUF_POST) |-> trig_r;
   endproperty
   a_post_wait: assert property (p_post_wait) else $error("stored before event");

   property p_start_full;
      (conv_ok && auto_run && buffer_capture_mode_r == BUF_START && fill_r == FILL_LAST)
         |=> !o_busy && fill_r == FILL_FULL;
   endproperty
   a_start_full: assert property (p_start_full) else $error("burst did not stop");

   property p_own_acc;
      (conv_ok && hp_run && !o_conv_ch) |=> acc_r[1] == $past(acc_r[1]);
   endproperty
   a_own_acc: assert property (p_own_acc) else $error("wrong accumulator");

   property p_hp_zero;
      (data_rd && operating_mode_select_r == OPM_HP) |=> o_rdata == '0;
   endproperty
   a_hp_zero: assert property (p_hp_zero) else $error("buffer read not zero");

   property p_wake;
      s_hp_last |=> s_idle_done;
   endproperty
   a_wake: assert property (p_wake) else $error("busy did not fall");

   property p_flag_clr;
      (i_wr && i_addr == A_HI_FLAGS && i_wdata[1:0] == FLAG_CLR && !conv_ok)
         |=> hi_flag_r == '0;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");

endmodule

// ===== verif/asq_conv_model.sv
`timescale 1ns/100ps
module asq_conv_model #(
   parameter logic [11:0] V0 = 12'h123,
   parameter logic [11:0] V1 = 12'h456
) (
   input wire logic i_core_clk,
   input wire logic i_start,
   input wire logic i_ch,
   output logic o_done,
   output logic [11:0] o_data
);
   // ***********************
   // converter with fixed latency
   // ***********************
   logic pend_r = 1'b0;
   logic [1:0] cnt_r = 2'h0;
   initial o_done = 1'b0;
   initial o_data = 12'h000;
   always @(posedge i_core_clk) begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_start) begin
         pend_r <= 1'b1;
         cnt_r <= 2'h2;
      end else if (pend_r && cnt_r == 2'h0) begin
         pend_r <= 1'b0;
         o_done <= 1'b1;
         o_data <= i_ch ? V1 : V0;
      end else if (pend_r) begin
         cnt_r <= cnt_r - 2'h1;
      end
   end
endmodule

// ===== verif/autonomous_sampling_sequencer_tb.sv
`timescale 1ns/100ps
module autonomous_sampling_sequencer_tb;
   import asq_pkg::*;
   // ***********************
   // stimulus and checks
   // ***********************
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [AW-1:0] i_addr = 5'h00;
   logic [DW-1:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_scl = 1'b0;
   logic i_host_read = 1'b0;
   logic [DW-1:0] o_rdata, o_man_data, q;
   logic o_conv_start, o_conv_ch, i_conv_done, o_alert, o_busy, o_man_valid;
   logic [SW-1:0] i_conv_data;
   int miscompares = 0;
   int compares = 0;
   initial forever #20 i_core_clk = ~i_core_clk;
   asq_core #(.LOW_OSC_DIV(4), .ACC_CNT(4)) uut (.i_core_clk, .i_nrst, .i_addr, .i_wdata,
      .i_wr, .i_rd, .o_rdata, .i_scl, .i_host_read, .o_conv_start, .o_conv_ch, .i_conv_done,
      .i_conv_data, .o_alert, .o_busy, .o_man_valid, .o_man_data);
   asq_conv_model conv (.i_core_clk, .i_start(o_conv_start), .i_ch(o_conv_ch),
      .o_done(i_conv_done), .o_data(i_conv_data));
   task automatic results();
      if (miscompares == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(negedge i_core_clk);
      q = o_rdata;
   endtask
   int cycles = 0;
   task automatic wait_for(input int what);
      for (cycles = 0; cycles < 4000; cycles++) begin
         @(negedge i_core_clk);
         if (what == 2 && o_man_valid === 1'b1) return;
         if (what == 1 && o_busy === 1'b0) return;
         if (what == 0 && o_alert === 1'b1) return;
      end
      chk(16'h0000, 16'h0001);
      results();
   endtask
   task automatic s_manual();
      i_host_read <= 1'b1;
      repeat (18) begin
         repeat (4) @(posedge i_core_clk);
         i_scl <= 1'b1;
         repeat (4) @(posedge i_core_clk);
         i_scl <= 1'b0;
      end
      wait_for(2);
      chk(o_man_data, {4'h0, 12'h123});
      @(posedge i_core_clk);
      i_host_read <= 1'b0;
   endtask
   task automatic s_burst();
      wr(A_ABORT, 16'h0001);
      wr(A_SCAN, {14'h0000, SCAN_BOTH});
      wr(A_OP_MODE, {13'h0000, OPM_AUTO});
      wr(A_BUF_MODE, {13'h0000, BUF_START});
      wr(A_START, 16'h0001);
      wait_for(1'b1);
      rd(A_STATUS);
      chk({11'h000, q[4:0]}, 16'h0010);
      for (int i = 0; i < 16; i++) begin
         rd(A_DATA);
         chk(q, (i % 2) ? 16'h1456 : 16'h0123);
      end
   endtask
   task automatic s_precision();
      wr(A_ABORT, 16'h0001);
      wr(A_OP_MODE, {13'h0000, OPM_HP});
      wr(A_ACCUM_EN, 16'h0001);
      wr(A_START, 16'h0001);
      wait_for(1'b1);
      rd(A_ACC_FIRST);
      chk(q, 16'h048C);
      rd(A_ACC_SECOND);
      chk(q, 16'h1158);
      rd(A_STATUS);
      chk({15'h0000, q[7]}, 16'h0001);
      rd(A_DATA);
      chk(q, 16'h0000);
   endtask
   task automatic s_alert();
      wr(A_ABORT, 16'h0001);
      wr(A_OP_MODE, {13'h0000, OPM_AUTO});
      wr(A_BUF_MODE, {13'h0000, BUF_STOP});
      wr(A_LIM_HI0, 16'h0100);
      wr(A_EVT_EN, 16'h0001);
      wr(A_CMP_EN, 16'h0001);
      wr(A_START, 16'h0001);
      wait_for(1'b0);
      repeat (200) @(posedge i_core_clk);
      wr(A_ABORT, 16'h0001);
      repeat (8) @(posedge i_core_clk);
      rd(A_HI_FLAGS);
      chk({15'h0000, q[0]}, 16'h0001);
      rd(A_STATUS);
      chk({9'h000, q[6:0]}, 16'h0010);
      wr(A_HI_FLAGS, {14'h0000, FLAG_CLR});
      repeat (3) @(negedge i_core_clk);
      chk({15'h0000, o_alert}, 16'h0000);
   endtask
   task automatic s_pre();
      wr(A_ABORT, 16'h0001);
      wr(A_BUF_MODE, {13'h0000, BUF_PRE});
      wr(A_LIM_HI1, 16'h0400);
      wr(A_EVT_EN, 16'h0002);
      wr(A_START, 16'h0001);
      wait_for(1'b1);
      rd(A_STATUS);
      chk({9'h000, q[6:0]}, 16'h0001);
      rd(A_DATA);
      chk(q, 16'h0123);
      rd(A_HI_FLAGS);
      chk({14'h0000, q[1:0]}, 16'h0002);
   endtask
   task automatic s_post();
      wr(A_ABORT, 16'h0001);
      wr(A_HI_FLAGS, {14'h0000, FLAG_CLR});
      wr(A_BUF_MODE, {13'h0000, BUF_POST});
      wr(A_EVT_EN, 16'h0001);
      wr(A_OSC, 16'h0001);
      wr(A_INTERVAL, 16'h0003);
      wr(A_START, 16'h0001);
      wait_for(1'b1);
      chk(16'(cycles > 200), 16'h0001);
      rd(A_STATUS);
      chk({9'h000, q[6:0]}, 16'h0050);
      for (int i = 0; i < 16; i++) begin
         rd(A_DATA);
         chk(q, (i % 2) ? 16'h0123 : 16'h1456);
      end
   endtask
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      s_manual();
      s_burst();
      s_precision();
      s_alert();
      s_pre();
      s_post();
      results();
   end
endmodule
